// file: rtl/sse_exec.sv
// Execute stage for byte and halfword stores, sign extension and single-bit right shifts.
`timescale 1ns/1ps
`include "sse_defines.svh"
module sse_exec (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sse_pkg::sse_xlat_t xlat,
  output logic [31:0] xlat_addr,
  output sse_pkg::sse_mem_wr_t mem_wr
);
  import sse_pkg::*;

  function automatic sse_op_t dec_op(input logic [3:0] code);
    case (code)
      `SSE_CODE_SBI: dec_op = OP_SBI;
      `SSE_CODE_SB: dec_op = OP_SB;
      `SSE_CODE_SHI: dec_op = OP_SHI;
      `SSE_CODE_SH: dec_op = OP_SH;
      `SSE_CODE_SIGN_EXTEND_HALF_OP: dec_op = OP_SIGN_EXTEND_HALF_OP;
      `SSE_CODE_SIGN_EXTEND_BYTE_OP: dec_op = OP_SIGN_EXTEND_BYTE_OP;
      `SSE_CODE_SRA: dec_op = OP_SRA;
      `SSE_CODE_SRC: dec_op = OP_SRC;
      `SSE_CODE_SRL: dec_op = OP_SRL;
      default: dec_op = OP_NONE;
    endcase
  endfunction

  function automatic logic is_half(input sse_op_t op);
    is_half = (op == OP_SH) || (op == OP_SHI);
  endfunction

  function automatic logic is_imm(input sse_op_t op);
    is_imm = (op == OP_SBI) || (op == OP_SHI);
  endfunction

  // Big-endian byte lanes.
  // Address byte 0 is the most significant lane, so lane enables count down from bit 3.
  function automatic logic [3:0] lane_be(input logic half, input logic [1:0] a);
    if (half) begin
      lane_be = a[1] ? 4'h3 : 4'hc;
    end else begin
      lane_be = 4'h8 >> a;
    end
  endfunction

  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] dval_reg;
  logic [31:0] imm_reg;
  logic [4:0] didx_reg;
  logic [31:0] result_reg;
  logic [31:0] addr_reg;
  logic [31:0] addr_hi_reg;
  logic rbit_reg;
  logic ea_reg;
  logic done_reg;
  logic fin_reg;
  sse_cfg_t cfg_reg;
  sse_msr_t msr_reg;
  sse_esr_t esr_reg;
  sse_op_t op_reg;
  sse_state_t state_reg;
  sse_mem_wr_t mem_wr_reg;

  logic addr_ok;
  logic cmd_wr;
  logic start;
  logic fin;
  logic store;
  logic illegal;
  logic priv;
  logic miss;
  logic prot;
  logic denied;
  logic misal;
  logic st_imm;
  logic st_ea;
  logic [31:0] st_off;
  logic [31:0] st_lo;
  logic [31:0] st_hi;
  logic [31:0] rd_mux;
  logic [31:0] wr_lo;
  sse_op_t st_op;

  // The slave never inserts wait states and always answers OKAY.
  assign addr_ok = hsel && htrans[1] && hready;
  assign cmd_wr = wr_pend_reg && (wr_ofs_reg == `SSE_OFS_CMD);
  assign start = (state_reg == ST_IDLE) && cmd_wr;
  assign fin = ((state_reg == ST_EXEC) && (cfg_reg.area != `SSE_AREA_SLOW))
    || (state_reg == ST_WAIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_ofs_reg <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  always_comb begin
    unique case (haddr[7:0])
      `SSE_OFS_OPA: rd_mux = opa_reg;
      `SSE_OFS_OPB: rd_mux = opb_reg;
      `SSE_OFS_DVAL: rd_mux = dval_reg;
      `SSE_OFS_IMM: rd_mux = imm_reg;
      `SSE_OFS_DIDX: rd_mux = {27'h0, didx_reg};
      `SSE_OFS_CFG: rd_mux = {25'h0, cfg_reg};
      `SSE_OFS_MSR: rd_mux = {27'h0, msr_reg};
      `SSE_OFS_ESR: rd_mux = {17'h0, esr_reg};
      `SSE_OFS_RESULT: rd_mux = result_reg;
      `SSE_OFS_STATUS: rd_mux = {30'h0, done_reg, state_reg != ST_IDLE};
      default: rd_mux = 32'h0;
    endcase
  end

  // Operands written while an operation runs change the inputs it is using.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_reg <= 32'h0;
      opb_reg <= 32'h0;
      dval_reg <= 32'h0;
      imm_reg <= 32'h0;
      didx_reg <= 5'h00;
      cfg_reg <= `SSE_CFG_RESET;
    end else if (wr_pend_reg) begin
      unique case (wr_ofs_reg)
        `SSE_OFS_OPA: opa_reg <= hwdata;
        `SSE_OFS_OPB: opb_reg <= hwdata;
        `SSE_OFS_DVAL: dval_reg <= hwdata;
        `SSE_OFS_IMM: imm_reg <= hwdata;
        `SSE_OFS_DIDX: didx_reg <= hwdata[4:0];
        `SSE_OFS_CFG: cfg_reg <= hwdata[6:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    st_op = dec_op(hwdata[3:0]);
    st_imm = is_imm(st_op);
    st_ea = hwdata[`SSE_CMD_EA_BIT] && !st_imm;
    // Offset sign extension.
    // A prefix word in the upper half of the immediate register replaces the extension.
    st_off = hwdata[`SSE_CMD_PFX_BIT] ? imm_reg : {{16{imm_reg[15]}}, imm_reg[15:0]};
    if (st_ea) begin
      st_hi = opa_reg;
      st_lo = opb_reg;
    end else begin
      st_hi = 32'h0;
      st_lo = opa_reg + (st_imm ? st_off : opb_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_reg <= OP_NONE;
      rbit_reg <= 1'b0;
      ea_reg <= 1'b0;
      addr_reg <= 32'h0;
      addr_hi_reg <= 32'h0;
    end else if (start) begin
      op_reg <= st_op;
      rbit_reg <= hwdata[`SSE_CMD_R_BIT] && !st_imm;
      ea_reg <= st_ea;
      addr_reg <= st_lo;
      addr_hi_reg <= st_hi;
    end
  end

  // One or two cycles.
  // A command written while busy is dropped; software polls the busy bit first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (cmd_wr) begin
          state_reg <= ST_EXEC;
        end
        ST_EXEC: if (cfg_reg.area == `SSE_AREA_SLOW) begin
          state_reg <= ST_WAIT;
        end else begin
          state_reg <= ST_IDLE;
        end
        ST_WAIT: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign store = (op_reg == OP_SB) || (op_reg == OP_SBI) || is_half(op_reg);
  assign illegal = (op_reg == OP_NONE) || (rbit_reg && !cfg_reg.reorder)
    || (ea_reg && !(cfg_reg.wide && cfg_reg.data32));
  assign priv = ea_reg && cfg_reg.physical_addr_extension && !cfg_reg.allow;
  assign miss = msr_reg.virtual_mode_bit && xlat.miss;
  assign denied = xlat.no_access && msr_reg.user_mode_bit;
  assign prot = msr_reg.virtual_mode_bit && (xlat.read_only || denied);
  assign misal = is_half(op_reg) && addr_reg[0];
  assign wr_lo = rbit_reg ? (addr_reg ^ (is_half(op_reg) ? 32'h2 : 32'h3)) : addr_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      esr_reg <= '0;
      msr_reg <= `SSE_MSR_RESET;
    end else if (fin && store && !illegal && !priv && (miss || prot)) begin
      msr_reg.saved_user_mode <= msr_reg.user_mode_bit;
      msr_reg.saved_virtual_mode <= msr_reg.virtual_mode_bit;
      msr_reg.user_mode_bit <= 1'b0;
      msr_reg.virtual_mode_bit <= 1'b0;
      esr_reg.s <= 1'b1;
      if (miss) begin
        esr_reg.exception_cause <= `SSE_EC_TLB_MISS;
      end else begin
        esr_reg.exception_cause <= `SSE_EC_STORAGE;
        esr_reg.zone_denied_flag <= denied;
      end
    end else if (fin && (store || illegal)) begin
      // Unknown codes reach here too, so they report illegal even though they never store.
      if (illegal) begin
        esr_reg.illegal <= 1'b1;
      end else if (priv) begin
        esr_reg.priv <= 1'b1;
        esr_reg.exception_cause <= `SSE_EC_PRIV;
      end else if (misal) begin
        esr_reg.exception_cause <= `SSE_EC_UNALIGNED;
        esr_reg.w <= 1'b0;
        esr_reg.s <= 1'b1;
        esr_reg.rx <= didx_reg;
      end
    end else if (fin && (op_reg == OP_SRA || op_reg == OP_SRC || op_reg == OP_SRL)) begin
      msr_reg.carry <= opa_reg[0];
    end else if (wr_pend_reg && wr_ofs_reg == `SSE_OFS_ESR) begin
      esr_reg <= '0;
    end else if (wr_pend_reg && wr_ofs_reg == `SSE_OFS_MSR) begin
      msr_reg <= hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= 32'h0;
    end else if (fin) begin
      unique case (op_reg)
        OP_SIGN_EXTEND_HALF_OP: result_reg <= {{16{opa_reg[15]}}, opa_reg[15:0]};
        OP_SIGN_EXTEND_BYTE_OP: result_reg <= {{24{opa_reg[7]}}, opa_reg[7:0]};
        OP_SRA: result_reg <= {opa_reg[31], opa_reg[31:1]};
        OP_SRC: result_reg <= {msr_reg.carry, opa_reg[31:1]};
        OP_SRL: result_reg <= {1'b0, opa_reg[31:1]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_wr_reg <= '0;
      done_reg <= 1'b0;
      fin_reg <= 1'b0;
    end else begin
      fin_reg <= fin;
      done_reg <= fin || (done_reg && !start);
      mem_wr_reg.en <= fin && store && !illegal && !priv && !miss && !prot && !misal;
      if (fin) begin
        mem_wr_reg.addr <= wr_lo;
        mem_wr_reg.addr_hi <= addr_hi_reg;
        mem_wr_reg.be <= lane_be(is_half(op_reg), wr_lo[1:0]);
        if (is_half(op_reg)) begin
          mem_wr_reg.data <= rbit_reg ? {2{dval_reg[7:0], dval_reg[15:8]}} : {2{dval_reg[15:0]}};
        end else begin
          mem_wr_reg.data <= {4{dval_reg[7:0]}};
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign xlat_addr = addr_reg;
  assign mem_wr = mem_wr_reg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_lat_fast;
    start && cfg_reg.area != `SSE_AREA_SLOW |-> ##2 fin_reg;
  endproperty
  a_lat_fast: assert property (p_lat_fast) else $error("fast latency wrong");

  property p_lat_slow;
    start && cfg_reg.area == `SSE_AREA_SLOW |-> ##1 !fin ##1 fin ##1 fin_reg;
  endproperty
  a_lat_slow: assert property (p_lat_slow) else $error("slow latency wrong");

  property p_miss;
    fin && store && !illegal && !priv && miss |=> esr_reg.exception_cause == `SSE_EC_TLB_MISS
      && esr_reg.s && !msr_reg.user_mode_bit && !msr_reg.virtual_mode_bit && !mem_wr.en;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not reported");

  property p_prot;
    fin && store && !illegal && !priv && !miss && prot |=>
      esr_reg.exception_cause == `SSE_EC_STORAGE && esr_reg.zone_denied_flag == $past(denied);
  endproperty
  a_prot: assert property (p_prot) else $error("storage fault wrong");

  property p_save;
    fin && store && !illegal && !priv && (miss || prot) |=>
      msr_reg.saved_user_mode == $past(msr_reg.user_mode_bit) && msr_reg.saved_virtual_mode;
  endproperty
  a_save: assert property (p_save) else $error("mode bits not saved");

  property p_align;
    fin && store && !illegal && !priv && !miss && !prot && misal |=>
      esr_reg.exception_cause == `SSE_EC_UNALIGNED && !esr_reg.w && esr_reg.rx == $past(didx_reg);
  endproperty
  a_align: assert property (p_align) else $error("unaligned fault wrong");

  property p_wr_clean;
    mem_wr.en |-> $past(fin) && !$past(miss) && !$past(prot) && !$past(misal)
      && (!mem_wr.addr[0] || !$past(is_half(op_reg)));
  endproperty
  a_wr_clean: assert property (p_wr_clean) else $error("write despite fault");

  property p_sign_extend_half_op;
    fin && op_reg == OP_SIGN_EXTEND_HALF_OP |=> result_reg[31:16] == {16{$past(opa_reg[15])}};
  endproperty
  a_sign_extend_half_op: assert property (p_sign_extend_half_op) else $error("halfword extend wrong");

  property p_carry;
    fin && (op_reg == OP_SRC) |=> msr_reg.carry == $past(opa_reg[0])
      && result_reg[31] == $past(msr_reg.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry shift wrong");

  c_store: cover property (start ##[1:2] mem_wr.en);
  c_miss: cover property (fin && store && miss);
  c_shift: cover property (fin && op_reg == OP_SRA);
endmodule

// file: rtl/sse_defines.svh
// Register offsets, field positions, reset values and codes for the execute block.
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

`define SSE_OFS_CMD 8'h00
`define SSE_OFS_OPA 8'h04
`define SSE_OFS_OPB 8'h08
`define SSE_OFS_DVAL 8'h0c
`define SSE_OFS_IMM 8'h10
`define SSE_OFS_DIDX 8'h14
`define SSE_OFS_CFG 8'h18
`define SSE_OFS_MSR 8'h1c
`define SSE_OFS_ESR 8'h20
`define SSE_OFS_RESULT 8'h24
`define SSE_OFS_STATUS 8'h28

`define SSE_CMD_R_BIT 4
`define SSE_CMD_EA_BIT 5
`define SSE_CMD_PFX_BIT 6

`define SSE_CODE_SBI 4'h0
`define SSE_CODE_SB 4'h1
`define SSE_CODE_SHI 4'h2
`define SSE_CODE_SH 4'h3
`define SSE_CODE_SIGN_EXTEND_HALF_OP 4'h4
`define SSE_CODE_SIGN_EXTEND_BYTE_OP 4'h5
`define SSE_CODE_SRA 4'h6
`define SSE_CODE_SRC 4'h7
`define SSE_CODE_SRL 4'h8

`define SSE_EC_TLB_MISS 5'h12
`define SSE_EC_STORAGE 5'h10
`define SSE_EC_UNALIGNED 5'h01
`define SSE_EC_PRIV 5'h07

`define SSE_CFG_RESET 7'h00
`define SSE_MSR_RESET 5'h00
`define SSE_AREA_SLOW 2'h1

`endif

// file: rtl/sse_pkg.sv
// Types shared by the execute block and its surroundings.
package sse_pkg;
  typedef enum logic [9:0] {
    OP_NONE = 10'h001, OP_SBI = 10'h002, OP_SB = 10'h004, OP_SHI = 10'h008,
    OP_SH = 10'h010, OP_SIGN_EXTEND_HALF_OP = 10'h020, OP_SIGN_EXTEND_BYTE_OP = 10'h040, OP_SRA = 10'h080,
    OP_SRC = 10'h100, OP_SRL = 10'h200
  } sse_op_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_EXEC = 3'h2, ST_WAIT = 3'h4} sse_state_t;
  typedef struct packed {
    logic miss;
    logic no_access;
    logic read_only;
  } sse_xlat_t;
  typedef struct packed {
    logic en;
    logic [31:0] addr_hi;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } sse_mem_wr_t;
  typedef struct packed {
    logic allow;
    logic physical_addr_extension;
    logic data32;
    logic wide;
    logic reorder;
    logic [1:0] area;
  } sse_cfg_t;
  typedef struct packed {
    logic saved_virtual_mode;
    logic saved_user_mode;
    logic virtual_mode_bit;
    logic user_mode_bit;
    logic carry;
  } sse_msr_t;
  typedef struct packed {
    logic priv;
    logic illegal;
    logic [4:0] rx;
    logic zone_denied_flag;
    logic s;
    logic w;
    logic [4:0] exception_cause;
  } sse_esr_t;
endpackage

// file: verif/sse_mem_model.sv
// Far-side model: translation lookup and a small byte-lane data memory.
`timescale 1ns/1ps
module sse_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire sse_pkg::sse_xlat_t fault,
  input wire logic [31:0] xlat_addr,
  input wire sse_pkg::sse_mem_wr_t mem_wr,
  output sse_pkg::sse_xlat_t xlat
);
  import sse_pkg::*;
  logic [7:0] mem_reg [0:63];
  // Only the high page carries faults, so a wrong store address shows up as a wrong fault.
  assign xlat = (xlat_addr[31:24] == 8'h80) ? fault : 3'h0;
  always_ff @(posedge hclk) begin
    if (hresetn && mem_wr.en) begin
      for (int i = 0; i < 4; i++) begin
        if (mem_wr.be[3 - i]) begin
          mem_reg[{mem_wr.addr[5:2], 2'(i)}] <= mem_wr.data[31 - 8 * i -: 8];
        end
      end
    end
  end
endmodule

// file: verif/sse_exec_test.sv
// Self-checking bench for the execute block: bus tasks, write scoreboard and scenarios.
`timescale 1ns/1ps
`include "sse_defines.svh"
module sse_exec_test;
  import sse_pkg::*;
  typedef struct packed {
    logic chk_hi;
    logic [31:0] hi;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
    logic [31:0] due;
  } sse_note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  sse_xlat_t xlat;
  sse_xlat_t fault = 3'h0;
  logic [31:0] xlat_addr;
  sse_mem_wr_t mem_wr;
  logic [31:0] cyc = 32'h0;
  logic [31:0] area_lat = 32'h2;
  int failures = 0;
  int cmp_count = 0;
  sse_note_t notes[$];
  sse_note_t nt;

  sse_exec u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xlat(xlat),
    .xlat_addr(xlat_addr), .mem_wr(mem_wr));
  sse_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .fault(fault),
    .xlat_addr(xlat_addr), .mem_wr(mem_wr), .xlat(xlat));

  initial begin
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 32'h1;

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // The master holds each phase until ready is seen high, then moves on.
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input string nm, input logic [7:0] ofs, input logic [31:0] exp,
      input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, ofs, 32'h0, q);
    chk(nm, exp & m, q & m);
  endtask

  task automatic run(input logic [6:0] cmd, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] dv, input logic [31:0] imm, input logic ok);
    sse_note_t n;
    logic [31:0] q;
    logic [31:0] ad;
    logic half;
    int k;
    half = (cmd[3:0] == `SSE_CODE_SHI) || (cmd[3:0] == `SSE_CODE_SH);
    if (cmd[0] == 1'b0) begin
      ad = a + (cmd[6] ? imm : {{16{imm[15]}}, imm[15:0]});
    end else begin
      ad = cmd[5] ? b : a + b;
    end
    n.addr = cmd[4] ? ad ^ (half ? 32'h2 : 32'h3) : ad;
    n.chk_hi = cmd[5];
    n.hi = a;
    n.be = half ? (n.addr[1] ? 4'h3 : 4'hc) : (4'h8 >> n.addr[1:0]);
    n.data = half ? {2{cmd[4] ? {dv[7:0], dv[15:8]} : dv[15:0]}} : {4{dv[7:0]}};
    bus(1'b1, `SSE_OFS_OPA, a, q);
    bus(1'b1, `SSE_OFS_OPB, b, q);
    bus(1'b1, `SSE_OFS_DVAL, dv, q);
    bus(1'b1, `SSE_OFS_IMM, imm, q);
    bus(1'b1, `SSE_OFS_DIDX, 32'h15, q);
    bus(1'b1, `SSE_OFS_CMD, {25'h0, cmd}, q);
    n.due = cyc + area_lat;
    if (ok) begin
      notes.push_back(n);
    end
    k = 0;
    do begin
      bus(1'b0, `SSE_OFS_STATUS, 32'h0, q);
      k++;
    end while (q[1] !== 1'b1 && k < 8);
    chk("status", 32'h2, q & 32'h3);
    if (ok && cmd[3:2] == 2'b00) begin
      chk("xlat_addr", ad, xlat_addr);
    end
  endtask

  task automatic scn(input logic [6:0] cfg, input logic [4:0] m, input logic [6:0] cmd,
      input logic [31:0] b, input sse_xlat_t f, input logic [31:0] exception_status_register,
      input logic [31:0] em, input logic [4:0] mexp, input logic ok);
    logic [31:0] q;
    bus(1'b1, `SSE_OFS_CFG, {25'h0, cfg}, q);
    bus(1'b1, `SSE_OFS_ESR, 32'h0, q);
    bus(1'b1, `SSE_OFS_MSR, {27'h0, m}, q);
    fault <= f;
    run(cmd, 32'h8000_0000, b, $urandom(), 32'h10, ok);
    rdc("esr", `SSE_OFS_ESR, exception_status_register, em);
    rdc("msr", `SSE_OFS_MSR, {27'h0, mexp});
  endtask

  // Every write seen must match the oldest noted one, at the noted cycle.
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && mem_wr.en === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected write", 32'h0, 32'h1);
      end else begin
        nt = notes.pop_front();
        chk("wr addr", nt.addr, mem_wr.addr);
        chk("wr be", {28'h0, nt.be}, {28'h0, mem_wr.be});
        chk("wr data", nt.data & lanes(nt.be), mem_wr.data & lanes(nt.be));
        chk("wr hi", nt.chk_hi ? nt.hi : 32'h0, mem_wr.addr_hi);
        chk("wr time", nt.due, cyc);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    end_sim();
  end

  initial begin
    logic [31:0] a;
    logic [31:0] q;
    logic [31:0] e;
    logic [3:0] code;
    logic c;
    void'($urandom(32'h9009));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("msr", `SSE_OFS_MSR, 32'h0);
    rdc("esr", `SSE_OFS_ESR, 32'h0);
    rdc("cfg", `SSE_OFS_CFG, 32'h0);
    rdc("status", `SSE_OFS_STATUS, 32'h0);
    bus(1'b1, 8'h40, 32'hffff_ffff, q);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      code = 4'h4 + 4'(i % 5);
      a = (i < 5) ? 32'h8080_8081 : $urandom();
      c = (i < 5) ? 1'b1 : 1'($urandom());
      bus(1'b1, `SSE_OFS_MSR, {31'h0, c}, q);
      run({3'h0, code}, a, 32'h0, 32'h0, 32'h0, 1'b0);
      case (code)
        `SSE_CODE_SIGN_EXTEND_HALF_OP: e = {{16{a[15]}}, a[15:0]};
        `SSE_CODE_SIGN_EXTEND_BYTE_OP: e = {{24{a[7]}}, a[7:0]};
        `SSE_CODE_SRA: e = {a[31], a[31:1]};
        `SSE_CODE_SRC: e = {c, a[31:1]};
        default: e = {1'b0, a[31:1]};
      endcase
      rdc("result", `SSE_OFS_RESULT, e);
      rdc("carry", `SSE_OFS_MSR, {31'h0, (code > 4'h5) ? a[0] : c});
    end
    $display("test data ops done");
    for (int ar = 0; ar < 3; ar++) begin
      area_lat = (ar == 1) ? 32'h3 : 32'h2;
      bus(1'b1, `SSE_OFS_CFG, {30'h7, 2'(ar)}, q);
      run({3'h0, `SSE_CODE_SBI}, 32'h1000_0003, 0, $urandom(), 32'hfffe, 1);
      run({3'h4, `SSE_CODE_SBI}, 32'h100, 0, $urandom(), 32'h1_0004, 1);
      run({3'h1, `SSE_CODE_SB}, 32'h200, 32'h2, $urandom(), 0, 1);
      run({3'h0, `SSE_CODE_SHI}, 32'h300, 0, $urandom(), 32'h8002, 1);
      a = $urandom() & 32'hffff_fffe;
      run({3'h0, `SSE_CODE_SH}, a, $urandom() & 32'h7fff_fffe, $urandom(), 0, 1);
      run({3'h1, `SSE_CODE_SH}, 32'h400, 32'h4, $urandom(), 0, 1);
      run({3'h2, `SSE_CODE_SH}, 32'h5, 32'h800, $urandom(), 0, 1);
    end
    area_lat = 32'h2;
    $display("test stores done");
    scn(7'h1c, 5'h07, {3'h0, `SSE_CODE_SH}, 32'h10, 3'h4, 32'h52, 32'h7fff, 5'h19, 0);
    scn(7'h1c, 5'h07, {3'h0, `SSE_CODE_SH}, 32'h11, 3'h5, 32'h52, 32'h7fff, 5'h19, 0);
    scn(7'h1c, 5'h07, {3'h0, `SSE_CODE_SB}, 32'h12, 3'h2, 32'hd0, 32'h7fff, 5'h19, 0);
    scn(7'h1c, 5'h04, {3'h0, `SSE_CODE_SHI}, 32'h0, 3'h1, 32'h50, 32'h7fff, 5'h10, 0);
    scn(7'h1c, 5'h04, {3'h0, `SSE_CODE_SH}, 32'h14, 3'h2, 32'h0, 32'h7fff, 5'h04, 1);
    scn(7'h1c, 5'h02, {3'h0, `SSE_CODE_SH}, 32'h13, 3'h4, 32'h1541, 32'h7fff, 5'h02, 0);
    $display("test faults done");
    scn(7'h18, 5'h0, {3'h1, `SSE_CODE_SH}, 32'h10, 3'h0, 32'h2000, 32'h2000, 5'h0, 0);
    scn(7'h14, 5'h0, {3'h2, `SSE_CODE_SH}, 32'h10, 3'h0, 32'h2000, 32'h2000, 5'h0, 0);
    scn(7'h0c, 5'h0, {3'h2, `SSE_CODE_SB}, 32'h10, 3'h0, 32'h2000, 32'h2000, 5'h0, 0);
    scn(7'h3c, 5'h0, {3'h2, `SSE_CODE_SH}, 32'h10, 3'h0, 32'h4007, 32'h401f, 5'h0, 0);
    scn(7'h7c, 5'h0, {3'h2, `SSE_CODE_SH}, 32'h20, 3'h0, 32'h0, 32'h7fff, 5'h0, 1);
    scn(7'h1c, 5'h0, 7'h09, 32'h0, 3'h0, 32'h2000, 32'h2000, 5'h0, 0);
    $display("test illegal done");
    repeat (5) @(posedge hclk);
    chk("pending writes", 32'h0, 32'(notes.size()));
    end_sim();
  end
endmodule
